// ---- shared/conv_ctrl_map.svh ----
// register offsets, field positions, reset values and counts of the interface control bank
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH

// register indices; byte address is four times the index
`define IDX_PIN_RX_CTRL      6'h00
`define IDX_FAULT_TEST_SYNC  6'h01
`define IDX_PATTERN_RESULT   6'h04
`define IDX_FAULT_FLAGS      6'h20
`define IDX_PATTERN_BASE     6'h21
`define IDX_PATTERN_LAST     6'h28

// reset values
`define RST_PIN_RX_CTRL      16'h44FC
`define RST_FAULT_TEST_SYNC  16'h600E
`define RST_PATTERN_WORD     14'h0000

// writable masks (reserved bits read as stored constant)
`define MASK_PIN_RX_CTRL     16'hF6FD
`define MASK_FAULT_TEST_SYNC 16'hDEFE
`define FIXED_FAULT_TEST_SYNC 16'h2000

// pin_receiver_control fields
`define B_ALARM_DRIVE        6
`define B_ALARM_POL          5
`define B_ALIGN_RX           4
`define B_SYNC_RX            3
`define B_WORD_CLK_RX        2
`define B_SYNC_ONLY          0

// fault_test_sync_control fields
`define B_PATTERN_TEST       15
`define B_B_SIDE_CLK         14
`define B_AUTO_CLEAR         12
`define B_CONV_CLK_OFF       11
`define B_WORD_CLK_OFF       10
`define B_COLLISION_OFF      9
`define B_INVERT_A           7
`define B_INVERT_B           6
`define B_SW_SYNC            5
`define B_SW_SYNC_MODE       4
`define B_GAP_TWO            3
`define B_GAP_ONE            2
`define B_COLLISION          1

// fault flag positions
`define F_COLLISION          0
`define F_GAP_ONE            1
`define F_GAP_TWO            2
`define F_PATTERN            3

// counts
`define AUTO_CLEAR_COUNT     64
`define PATTERN_LEN          8

`endif

// ---- shared/conv_ctrl_pkg.sv ----
// types shared by the interface control bank
package conv_ctrl_pkg;
   typedef logic [13:0] sample_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_s;

   typedef struct packed {
      logic ptr_collision;
      logic ptr_gap_one;
      logic ptr_gap_two;
      logic conv_clk_lost;
      logic word_clk_lost;
   } monitor_in_s;

   typedef struct packed {
      logic align_rx;
      logic sync_rx;
      logic word_clk_rx;
   } rx_power_s;
endpackage

// ---- src/converter_interface_control_regs.sv ----
// control registers, sync selection, pattern checker and fault logic of the input interface
`include "conv_ctrl_map.svh"
// Operation
// - drive bit set drives fault pin, else released
// - polarity bit selects fault active level
// - bit four powers alignment receiver
// - bit three powers synchronization receiver
// - bit two powers input word clock receiver
// - sync-only mode: chip sync (pin or strobe) syncs both FIFO sides
// - pattern test compares eight samples; else gated
// - channel B clock enable gates B checker, FIFO
// - auto clear flags after 64 good samples
// - converter clock loss forces output off
// - input clock loss forces output off
// - pointer collision forces output off
// - invert converter A word when set
// - invert converter B word when set
// - software sync rising edge makes one pulse
// - register strobe mode replaces pin sync
// - fault when pointers two apart
// - fault when pointers one apart
// - fault when pointers collide
// - failing input bits latched, write clears
module converter_interface_control_regs (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire conv_ctrl_pkg::wb_req_s wb_req,
   output conv_ctrl_pkg::wb_rsp_s      wb_rsp,
   input  wire conv_ctrl_pkg::sample_t data_a,
   input  wire conv_ctrl_pkg::sample_t data_b,
   input  wire logic                   sample_valid,
   input  wire logic                   sync_pin,
   input  wire logic                   align_pin,
   input  wire conv_ctrl_pkg::monitor_in_s monitor,
   output conv_ctrl_pkg::rx_power_s    rx_power,
   output logic                        alarm_o,
   output logic                        alarm_oe,
   output logic                        fifo_wr_sync,
   output logic                        fifo_rd_sync,
   output logic                        pattern_clk_en,
   output logic                        b_side_clk_en,
   output logic                        output_off,
   output conv_ctrl_pkg::sample_t      dac_a_word,
   output conv_ctrl_pkg::sample_t      dac_b_word
);
   logic [15:0]            pin_ctrl_r;
   logic [15:0]            fts_ctrl_r;
   conv_ctrl_pkg::sample_t pattern_r [`PATTERN_LEN];
   conv_ctrl_pkg::sample_t result_r;
   logic [3:0]             flags_r;
   logic [3:0]             flag_set;
   logic                   ack_r;
   logic [31:0]            rdat_r;
   logic                   wr_go;
   logic [5:0]             idx;
   logic [15:0]            wdat;
   logic                   sync_pin_d_r;
   logic                   align_d_r;
   logic                   sw_sync_prev_r;
   logic                   sw_sync_pulse;
   logic                   chip_sync;
   logic [2:0]             pat_idx_r;
   logic [2:0]             pat_idx_cur;
   conv_ctrl_pkg::sample_t miss_a;
   conv_ctrl_pkg::sample_t miss_b;
   conv_ctrl_pkg::sample_t miss;
   logic [5:0]             good_cnt_r;
   logic                   auto_clr;
   logic                   result_clr;
   logic                   flags_clr_wr;
   logic [3:0]             flags_wr_mask;

   // merges a byte-enabled write into a 16-bit value
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // wishbone slave: one wait state, write acts on the ack edge
   assign idx   = wb_req.adr[7:2];
   assign wdat  = wb_req.dat[15:0];
   assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & ack_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_r <= 32'h0000_0000;
      end else if (wb_req.cyc & wb_req.stb & ~ack_r) begin
         rdat_r <= 32'h0000_0000;
         if (idx == `IDX_PIN_RX_CTRL) begin
            rdat_r[15:0] <= pin_ctrl_r;
         end else if (idx == `IDX_FAULT_TEST_SYNC) begin
            rdat_r[15:0] <= fts_ctrl_r;
         end else if (idx == `IDX_PATTERN_RESULT) begin
            rdat_r[13:0] <= result_r;
         end else if (idx == `IDX_FAULT_FLAGS) begin
            rdat_r[3:0] <= flags_r;
         end else if (idx >= `IDX_PATTERN_BASE && idx <= `IDX_PATTERN_LAST) begin
            rdat_r[13:0] <= pattern_r[3'(idx - `IDX_PATTERN_BASE)];
         end
      end
   end

   assign wb_rsp.ack = ack_r;
   assign wb_rsp.dat = rdat_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_ctrl_r <= `RST_PIN_RX_CTRL;
      end else if (wr_go && idx == `IDX_PIN_RX_CTRL) begin
         pin_ctrl_r <= merge16(pin_ctrl_r, wb_req.dat, wb_req.sel) & `MASK_PIN_RX_CTRL;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fts_ctrl_r <= `RST_FAULT_TEST_SYNC;
      end else if (wr_go && idx == `IDX_FAULT_TEST_SYNC) begin
         fts_ctrl_r <= (merge16(fts_ctrl_r, wb_req.dat, wb_req.sel) & `MASK_FAULT_TEST_SYNC)
                       | `FIXED_FAULT_TEST_SYNC;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `PATTERN_LEN; i++) begin
            pattern_r[i] <= `RST_PATTERN_WORD;
         end
      end else if (wr_go && idx >= `IDX_PATTERN_BASE && idx <= `IDX_PATTERN_LAST) begin
         pattern_r[3'(idx - `IDX_PATTERN_BASE)] <=
            14'(merge16({2'b00, pattern_r[3'(idx - `IDX_PATTERN_BASE)]}, wb_req.dat,
                        wb_req.sel));
      end
   end

   // receiver power and clock enables
   assign rx_power.align_rx    = pin_ctrl_r[`B_ALIGN_RX];
   assign rx_power.sync_rx     = pin_ctrl_r[`B_SYNC_RX];
   assign rx_power.word_clk_rx = pin_ctrl_r[`B_WORD_CLK_RX];
   assign pattern_clk_en       = fts_ctrl_r[`B_PATTERN_TEST];
   assign b_side_clk_en        = fts_ctrl_r[`B_B_SIDE_CLK];

   // sync source selection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_pin_d_r   <= 1'b0;
         align_d_r      <= 1'b0;
         sw_sync_prev_r <= 1'b0;
      end else begin
         sync_pin_d_r   <= sync_pin;
         align_d_r      <= align_pin;
         sw_sync_prev_r <= fts_ctrl_r[`B_SW_SYNC];
      end
   end

   assign sw_sync_pulse = fts_ctrl_r[`B_SW_SYNC] & ~sw_sync_prev_r;
   assign chip_sync = fts_ctrl_r[`B_SW_SYNC_MODE] ? sw_sync_pulse
                                                  : (sync_pin & ~sync_pin_d_r);
   assign fifo_wr_sync = chip_sync;
   assign fifo_rd_sync = pin_ctrl_r[`B_SYNC_ONLY] ? chip_sync
                                                  : (align_pin & ~align_d_r);

   // pattern checker; sample zero arrives with the sync rise
   assign pat_idx_cur = chip_sync ? 3'h0 : pat_idx_r;
   assign miss_a = data_a ^ pattern_r[pat_idx_cur];
   assign miss_b = fts_ctrl_r[`B_B_SIDE_CLK] ? (data_b ^ pattern_r[pat_idx_cur])
                                             : 14'h0000;
   assign miss = (pattern_clk_en & sample_valid) ? (miss_a | miss_b) : 14'h0000;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pat_idx_r <= 3'h0;
      end else if (pattern_clk_en && sample_valid) begin
         pat_idx_r <= pat_idx_cur + 3'h1;
      end else if (chip_sync) begin
         pat_idx_r <= 3'h0;
      end
   end

   assign result_clr = wr_go && idx == `IDX_PATTERN_RESULT;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 14'h0000;
      end else begin
         result_r <= (result_r & ~(result_clr ? wdat[13:0] : 14'h0000)) | miss;
      end
   end

   // fault flags: set wins over clear
   always_comb begin
      flag_set = 4'h0;
      flag_set[`F_COLLISION] = fts_ctrl_r[`B_COLLISION] & monitor.ptr_collision;
      flag_set[`F_GAP_ONE]   = fts_ctrl_r[`B_GAP_ONE] & monitor.ptr_gap_one;
      flag_set[`F_GAP_TWO]   = fts_ctrl_r[`B_GAP_TWO] & monitor.ptr_gap_two;
      flag_set[`F_PATTERN]   = |miss;
   end

   assign flags_clr_wr  = wr_go && idx == `IDX_FAULT_FLAGS;
   assign flags_wr_mask = flags_clr_wr ? wdat[3:0] : 4'h0;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         good_cnt_r <= 6'h00;
      end else if (!fts_ctrl_r[`B_AUTO_CLEAR] || |flag_set) begin
         good_cnt_r <= 6'h00;
      end else if (sample_valid) begin
         good_cnt_r <= good_cnt_r + 6'h01;
      end
   end

   assign auto_clr = fts_ctrl_r[`B_AUTO_CLEAR] && sample_valid && ~|flag_set
                     && good_cnt_r == 6'(`AUTO_CLEAR_COUNT - 1);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= 4'h0;
      end else if (auto_clr) begin
         flags_r <= 4'h0;
      end else begin
         flags_r <= (flags_r & ~flags_wr_mask) | flag_set;
      end
   end

   // fault pin and output shutdown
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_o <= 1'b0;
      end else begin
         alarm_o <= (|flags_r) ~^ pin_ctrl_r[`B_ALARM_POL];
      end
   end

   assign alarm_oe = pin_ctrl_r[`B_ALARM_DRIVE];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_off <= 1'b0;
      end else begin
         output_off <= (fts_ctrl_r[`B_CONV_CLK_OFF] & monitor.conv_clk_lost)
                     | (fts_ctrl_r[`B_WORD_CLK_OFF] & monitor.word_clk_lost)
                     | (fts_ctrl_r[`B_COLLISION_OFF] & monitor.ptr_collision);
      end
   end

   // converter words with optional inversion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_a_word <= 14'h0000;
      end else if (sample_valid) begin
         dac_a_word <= fts_ctrl_r[`B_INVERT_A] ? ~data_a : data_a;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_b_word <= 14'h0000;
      end else if (sample_valid && fts_ctrl_r[`B_B_SIDE_CLK]) begin
         dac_b_word <= fts_ctrl_r[`B_INVERT_B] ? ~data_b : data_b;
      end
   end

   // checks
   AST_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      alarm_oe == pin_ctrl_r[`B_ALARM_DRIVE]) else $error("fault pin drive mismatch");
   AST_ALARM: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> alarm_o == ($past(|flags_r) ~^ $past(pin_ctrl_r[`B_ALARM_POL])))
      else $error("fault pin level wrong");
   AST_SW_SYNC: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fts_ctrl_r[`B_SW_SYNC_MODE] && $rose(fts_ctrl_r[`B_SW_SYNC]) |-> fifo_wr_sync
      ##1 !fifo_wr_sync) else $error("software sync not a single pulse");
   AST_PIN_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fts_ctrl_r[`B_SW_SYNC_MODE] && !sw_sync_pulse |-> !fifo_wr_sync)
      else $error("pin sync leaked in strobe mode");
   AST_SYNC_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pin_ctrl_r[`B_SYNC_ONLY] |-> fifo_rd_sync == fifo_wr_sync)
      else $error("read side not synced by chip sync");
   AST_GAP_TWO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fts_ctrl_r[`B_GAP_TWO] && monitor.ptr_gap_two |=> flags_r[`F_GAP_TWO])
      else $error("gap two fault not latched");
   AST_GAP_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fts_ctrl_r[`B_GAP_ONE] && monitor.ptr_gap_one |=> flags_r[`F_GAP_ONE])
      else $error("gap one fault not latched");
   AST_COLL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fts_ctrl_r[`B_COLLISION] && monitor.ptr_collision |=> flags_r[`F_COLLISION])
      else $error("collision fault not latched");
   AST_SHUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fts_ctrl_r[`B_CONV_CLK_OFF] && monitor.conv_clk_lost)
      || (fts_ctrl_r[`B_WORD_CLK_OFF] && monitor.word_clk_lost)
      || (fts_ctrl_r[`B_COLLISION_OFF] && monitor.ptr_collision) |=> output_off)
      else $error("output not forced off on enabled cause");
   AST_INV_A: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sample_valid && fts_ctrl_r[`B_INVERT_A] |=> dac_a_word == ~$past(data_a))
      else $error("channel A word not inverted");
   AST_B_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !fts_ctrl_r[`B_B_SIDE_CLK] |=> $stable(dac_b_word)) else $error("B side moved gated");
   AST_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      |miss |=> (result_r & $past(miss)) == $past(miss)) else $error("fail bits lost");
   AST_AUTO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      auto_clr |=> flags_r == 4'h0) else $error("auto clear missed");

   COV_SW_SYNC: cover property (@(posedge ref_clk) disable iff (!rst_n) sw_sync_pulse);
   COV_PATTERN_FAIL: cover property (@(posedge ref_clk) disable iff (!rst_n)
      flags_r[`F_PATTERN]);
   COV_AUTO_CLEAR: cover property (@(posedge ref_clk) disable iff (!rst_n) auto_clr);
   COV_SHUTDOWN: cover property (@(posedge ref_clk) disable iff (!rst_n) output_off);
endmodule

// ---- bench/data_source.sv ----
// data source model: sample words and frame sync toward the control bank
module data_source (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   go,
   input  wire logic [3:0]             frames,
   input  wire logic [111:0]           pat,
   input  wire conv_ctrl_pkg::sample_t err_mask,
   output conv_ctrl_pkg::sample_t      data_a,
   output conv_ctrl_pkg::sample_t      data_b,
   output logic                        sample_valid,
   output logic                        sync_pin,
   output logic                        busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_r;
   logic [7:0] cnt_r;
   assign busy = (left_r != 8'h00);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         left_r       <= 8'h00;
         cnt_r        <= 8'h00;
         sample_valid <= 1'b0;
         sync_pin     <= 1'b0;
         data_a       <= 14'h0000;
         data_b       <= 14'h3FFF;
      end else if (go && !busy) begin
         left_r <= {1'b0, frames, 3'h0};
         cnt_r  <= 8'h00;
      end else if (busy) begin
         sample_valid <= 1'b1;
         sync_pin     <= (cnt_r[2:0] == 3'h0);
         data_a       <= pat[cnt_r[2:0]*14 +: 14] ^ ((cnt_r == 8'h00) ? err_mask : 14'h0000);
         data_b       <= pat[cnt_r[2:0]*14 +: 14];
         cnt_r        <= cnt_r + 8'h01;
         left_r       <= left_r - 8'h01;
      end else begin
         // idle: words keep moving, no sync
         sample_valid <= 1'b0;
         sync_pin     <= 1'b0;
         data_a       <= ~data_a;
         data_b       <= data_b + 14'h0123;
      end
   end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the interface control bank
`include "conv_ctrl_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                        ref_clk, rst_n, sample_valid, src_sync, tb_sync, sync_pin;
   logic                        align_pin, alarm_o, alarm_oe, fifo_wr_sync, fifo_rd_sync;
   logic                        pattern_clk_en, b_side_clk_en, output_off, go, busy;
   logic                        dac_on, v_q;
   logic [3:0]                  frames;
   logic [111:0]                pat;
   logic [15:0]                 cfg1, rd, v;
   conv_ctrl_pkg::wb_req_s      wb_req;
   conv_ctrl_pkg::wb_rsp_s      wb_rsp;
   conv_ctrl_pkg::monitor_in_s  monitor;
   conv_ctrl_pkg::rx_power_s    rx_power;
   conv_ctrl_pkg::sample_t      data_a, data_b, dac_a_word, dac_b_word, err_mask, ea_q, eb_q, m;
   int                          seed, error_cnt, checked, ws, rs;
   int                          wr_n = 0;
   int                          rd_n = 0;
   assign sync_pin = src_sync | tb_sync;
   converter_interface_control_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .data_a(data_a), .data_b(data_b), .sample_valid(sample_valid),
      .sync_pin(sync_pin), .align_pin(align_pin), .monitor(monitor), .rx_power(rx_power),
      .alarm_o(alarm_o), .alarm_oe(alarm_oe), .fifo_wr_sync(fifo_wr_sync),
      .fifo_rd_sync(fifo_rd_sync), .pattern_clk_en(pattern_clk_en),
      .b_side_clk_en(b_side_clk_en), .output_off(output_off), .dac_a_word(dac_a_word),
      .dac_b_word(dac_b_word));
   data_source src (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .frames(frames), .pat(pat),
      .err_mask(err_mask), .data_a(data_a), .data_b(data_b), .sample_valid(sample_valid),
      .sync_pin(src_sync), .busy(busy));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [5:0] idx, input logic [15:0] wd);
      int t;
      wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h3, {16'h0000, wd}};
      t = 0;
      do begin
         @(posedge ref_clk);
         t++;
      end while (wb_rsp.ack !== 1'b1 && t < 40);
      rd = wb_rsp.dat[15:0];
      chk("ack", wb_rsp.ack, 1'b1);
      wb_req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
      if (idx == `IDX_FAULT_TEST_SYNC) cfg1 = wd;
      wb(1'b1, idx, wd);
   endtask
   task automatic rdchk(input string what, input logic [5:0] idx, input logic [15:0] exp);
      wb(1'b0, idx, 16'h0000);
      chk(what, rd, exp);
   endtask
   task automatic run(input logic [3:0] n, input conv_ctrl_pkg::sample_t mk);
      int t;
      frames <= n;
      err_mask <= mk;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (2) @(posedge ref_clk);
      for (t = 0; busy && t < 200; t++) @(posedge ref_clk);
      chk("run_end", busy, 1'b0);
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic rise(input logic on_align);
      if (on_align) align_pin <= 1'b1;
      else tb_sync <= 1'b1;
      repeat (2) @(posedge ref_clk);
      align_pin <= 1'b0;
      tb_sync <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic sdelta(input int dw, input int dr);
      repeat (2) @(posedge ref_clk);
      chk("wr_sync", wr_n - ws, dw);
      chk("rd_sync", rd_n - rs, dr);
      ws = wr_n;
      rs = rd_n;
   endtask
   always @(posedge ref_clk) begin
      if (fifo_wr_sync === 1'b1) wr_n <= wr_n + 1;
      if (fifo_rd_sync === 1'b1) rd_n <= rd_n + 1;
      if (dac_on && v_q) begin
         chk("dac_a", dac_a_word, ea_q);
         chk("dac_b", dac_b_word, eb_q);
      end
      v_q <= sample_valid;
      ea_q <= data_a ^ {14{cfg1[7]}};
      if (sample_valid && cfg1[14]) eb_q <= data_b ^ {14{cfg1[6]}};
   end
   initial begin
      #(60000 * 10);
      error_cnt++;
      $display("watchdog expired");
      close_out();
   end
   initial begin
      seed = 27305;
      error_cnt = 0;
      checked = 0;
      rst_n = 1'b0;
      wb_req = '0;
      go = 1'b0;
      frames = 4'h0;
      pat = '0;
      err_mask = 14'h0000;
      tb_sync = 1'b0;
      align_pin = 1'b0;
      monitor = '0;
      dac_on = 1'b0;
      v_q = 1'b0;
      cfg1 = `RST_FAULT_TEST_SYNC;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk("pin_rx", `IDX_PIN_RX_CTRL, `RST_PIN_RX_CTRL);
      rdchk("fts", `IDX_FAULT_TEST_SYNC, `RST_FAULT_TEST_SYNC);
      chk("outs", {alarm_oe, rx_power, pattern_clk_en, b_side_clk_en, alarm_o}, 7'h7A);
      wr(6'h3F, 16'hFFFF);
      rdchk("unmapped", 6'h3F, 16'h0000);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         wr(`IDX_PIN_RX_CTRL, v);
         rdchk("pin_rx", `IDX_PIN_RX_CTRL, v & `MASK_PIN_RX_CTRL);
         chk("pins", {alarm_oe, rx_power, alarm_o}, {v[6], v[4], v[3], v[2], ~v[5]});
         v = $random(seed);
         wr(`IDX_FAULT_TEST_SYNC, v);
         rdchk("fts", 6'h01, (v & `MASK_FAULT_TEST_SYNC) | `FIXED_FAULT_TEST_SYNC);
         chk("clk_en", {pattern_clk_en, b_side_clk_en}, v[15:14]);
      end
      wr(`IDX_PIN_RX_CTRL, `RST_PIN_RX_CTRL);
      wr(`IDX_FAULT_FLAGS, 16'h000F);
      $display("register test done");
      for (int i = 0; i < 5; i++) begin
         wr(`IDX_FAULT_TEST_SYNC, {1'b0, i != 4, 6'h20, i[1], i[0], 6'h0E});
         dac_on = 1'b1;
         run(4'h2, 14'h0000);
         dac_on = 1'b0;
      end
      $display("invert test done");
      for (int k = 0; k < 8; k++) begin
         pat[k*14 +: 14] = $random(seed);
         wr(6'(`IDX_PATTERN_BASE + k), {2'b00, pat[k*14 +: 14]});
         rdchk("pat", 6'(`IDX_PATTERN_BASE + k), {2'b00, pat[k*14 +: 14]});
      end
      m = $random(seed) | 14'h2000;
      run(4'h1, m);
      rdchk("off_flags", `IDX_FAULT_FLAGS, 16'h0000);
      wr(`IDX_FAULT_TEST_SYNC, 16'hE00E);
      run(4'h1, 14'h0000);
      rdchk("result", `IDX_PATTERN_RESULT, 16'h0000);
      run(4'h1, m);
      rdchk("result", `IDX_PATTERN_RESULT, {2'b00, m});
      rdchk("flags", `IDX_FAULT_FLAGS, 16'h0008);
      chk("alarm_hi", alarm_o, 1'b1);
      wr(`IDX_PIN_RX_CTRL, 16'h44DC);
      repeat (3) @(posedge ref_clk);
      chk("alarm_lo", alarm_o, 1'b0);
      wr(`IDX_PATTERN_RESULT, 16'h3FFF);
      wr(`IDX_FAULT_FLAGS, 16'h000F);
      rdchk("result", `IDX_PATTERN_RESULT, 16'h0000);
      chk("alarm_clr", alarm_o, 1'b1);
      wr(`IDX_PIN_RX_CTRL, `RST_PIN_RX_CTRL);
      wr(`IDX_FAULT_TEST_SYNC, 16'hF00E);
      run(4'h8, m);
      rdchk("early", `IDX_FAULT_FLAGS, 16'h0008);
      run(4'h1, 14'h0000);
      rdchk("auto", `IDX_FAULT_FLAGS, 16'h0000);
      rdchk("kept", `IDX_PATTERN_RESULT, {2'b00, m});
      $display("pattern test done");
      for (int i = 0; i < 6; i++) begin
         wr(`IDX_FAULT_TEST_SYNC, 16'h6000 | ((i < 3) ? (16'h0002 << (i % 3)) : 16'h0000));
         monitor <= 5'b10000 >> (i % 3);
         repeat (2) @(posedge ref_clk);
         monitor <= '0;
         rdchk("ptr_flag", `IDX_FAULT_FLAGS, (i < 3) ? (1 << (i % 3)) : 0);
         wr(`IDX_FAULT_FLAGS, 16'h000F);
         wr(`IDX_FAULT_TEST_SYNC, 16'h6000 | ((i < 3) ? (16'h0200 << (i % 3)) : 16'h0000));
         monitor <= (i % 3 == 0) ? 5'b10000 : ((i % 3 == 1) ? 5'b00001 : 5'b00010);
         repeat (2) @(posedge ref_clk);
         chk("off", output_off, i < 3);
         monitor <= '0;
         repeat (2) @(posedge ref_clk);
         chk("off_rel", output_off, 1'b0);
      end
      $display("fault test done");
      wr(`IDX_FAULT_TEST_SYNC, `RST_FAULT_TEST_SYNC);
      wr(`IDX_PIN_RX_CTRL, 16'h44FD);
      ws = wr_n;
      rs = rd_n;
      rise(1'b0);
      sdelta(1, 1);
      rise(1'b1);
      sdelta(0, 0);
      wr(`IDX_PIN_RX_CTRL, `RST_PIN_RX_CTRL);
      rise(1'b1);
      sdelta(0, 1);
      rise(1'b0);
      sdelta(1, 0);
      wr(`IDX_FAULT_TEST_SYNC, 16'h601E);
      sdelta(0, 0);
      wr(`IDX_FAULT_TEST_SYNC, 16'h603E);
      sdelta(1, 0);
      wr(`IDX_FAULT_TEST_SYNC, 16'h601E);
      sdelta(0, 0);
      rise(1'b0);
      sdelta(0, 0);
      $display("sync test done");
      close_out();
   end
endmodule
